// >>> verilog/dms_slice.sv
// Multiply-accumulate slice: pre-adder, multiplier, SIMD ALU, XOR and pattern detect
//
// Notes on behaviour
// RL1: A 27 by 18 multiplier takes both operands as signed two's complement and gives the full product.
// RL2: A 48-bit accumulator adds the arithmetic result into its held sum on every enabled cycle in OP_ACC mode (OP_ACC_SUB subtracts it).
// RL3: A run-time bypass sends two 48-bit operands straight to the ALU in place of the product.
// RL4: SIMD mode splits the path into two 24-bit or four 12-bit lanes with no carry between lanes.
// RL5: A logic unit computes any one of ten bitwise functions of the two operands.
// RL6: A pre-adder sums or differences two inputs ahead of the multiplier.
// RL7: A 96-bit XOR reduction yields parity per 12, 24, 48 or 96-bit group.
// RL8: A 48-bit masked pattern detector flags matches and drives convergent rounding.
// RL9: Pattern match on the logic result chains with a neighbour to span 96 bits.
// RL10: The accumulator counts up or down by one per enabled edge, direction selectable.
// RL11: Pipeline stages before and after the multiplier are selectable to trade latency for speed.
// RL12: All registers use one rising clock with enables, and a synchronous reset clears them.
`timescale 1ns/1ps
module dms_slice #(
    parameter bit USE_AREG = 1'b1,
    parameter bit USE_MREG = 1'b1,
    parameter int RND_BIT = 0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire dms_pkg::dms_ctl_t ctl,
    input wire dms_pkg::dms_din_t din,
    input wire dms_pkg::dms_pat_t pat,
    output logic [47:0] result,
    output logic [47:0] result_rnd,
    output logic pat_match,
    output logic pat_bmatch,
    output logic pat_wide,
    output logic [7:0] xor_par
);

    // ------------------------------------------------------------
    // Logic unit decode
    // ------------------------------------------------------------
    function automatic logic [47:0] dms_logic(
        input logic [3:0] fn,
        input logic [47:0] x,
        input logic [47:0] y
    );
        logic [47:0] r;
        r = '0;
        case (fn)
            dms_pkg::LF_AND: r = x & y;
            dms_pkg::LF_OR: r = x | y;
            dms_pkg::LF_XOR: r = x ^ y;
            dms_pkg::LF_XNOR: r = ~(x ^ y);
            dms_pkg::LF_NAND: r = ~(x & y);
            dms_pkg::LF_NOR: r = ~(x | y);
            dms_pkg::LF_ANDN: r = x & ~y;
            dms_pkg::LF_ORN: r = x | ~y;
            dms_pkg::LF_NOTX: r = ~x;
            dms_pkg::LF_NOTY: r = ~y;
            default: r = '0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    dms_pkg::dms_state_t s_q;
    dms_pkg::dms_state_t s_d;
    logic [26:0] pre_w;
    logic [26:0] mul_a;
    logic [17:0] mul_b;
    logic signed [44:0] prod_s;
    logic [47:0] prod_w;
    logic [47:0] prod_use;
    logic [47:0] x_w;
    logic [47:0] add_a;
    logic [47:0] add_b;
    logic add_sub;
    logic [47:0] add_sum;
    logic [47:0] alu_w;
    logic [95:0] xor_opnd;
    logic [7:0] grp12;

    // Wraps at 27 bits so the product keeps the multiplier's native width
    assign pre_w = ctl.preadd_en ? (ctl.pre_sub ? 27'(din.d - din.a)
                                                : 27'(din.d + din.a))
                                 : din.a; // RL6

    // Static stage choice: extra registers add a cycle each but cut the path
    assign mul_a = USE_AREG ? s_q.pre : pre_w; // RL11
    assign mul_b = USE_AREG ? s_q.b : din.b; // RL11
    assign prod_s = $signed(mul_a) * $signed(mul_b); // RL1
    assign prod_w = {{3{prod_s[44]}}, prod_s}; // RL1
    assign prod_use = USE_MREG ? s_q.prod : prod_w; // RL11
    assign x_w = ctl.bypass ? din.x : prod_use; // RL3

    always_comb
    begin
        add_a = din.y;
        add_b = x_w;
        add_sub = 1'b0;
        case (ctl.op)
            dms_pkg::OP_SUB: add_sub = 1'b1;
            dms_pkg::OP_ACC: add_a = s_q.acc; // RL2
            dms_pkg::OP_ACC_SUB:
            begin
                add_a = s_q.acc;
                add_sub = 1'b1;
            end
            default: add_sub = 1'b0;
        endcase
    end

    dms_simd_add #(
        .LANE_W(dms_pkg::LANE_W),
        .N_LANE(dms_pkg::N_LANE)
    ) dms_simd_add_inst (
        .op_a(add_a),
        .op_b(add_b),
        .sub(add_sub),
        .simd(ctl.simd),
        .sum(add_sum)
    );

    always_comb
    begin
        case (ctl.op)
            dms_pkg::OP_LOGIC: alu_w = dms_logic(ctl.logic_fn, x_w, din.y); // RL5
            dms_pkg::OP_COUNT: alu_w = ctl.count_up ? s_q.acc + dms_pkg::COUNT_STEP
                                                    : s_q.acc - dms_pkg::COUNT_STEP; // RL10
            default: alu_w = add_sum;
        endcase
    end

    // ------------------------------------------------------------
    // XOR reduction over the 96-bit operand pair
    // ------------------------------------------------------------
    assign xor_opnd = {din.y, x_w};

    genvar g;
    generate
        for (g = 0; g < dms_pkg::XOR_GRP; g++)
        begin : g_xor
            assign grp12[g] = ^xor_opnd[g*dms_pkg::LANE_W +: dms_pkg::LANE_W]; // RL7
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.pre = pre_w;
        s_d.b = din.b;
        s_d.prod = prod_w;
        if (ctl.acc_en)
        begin
            s_d.acc = alu_w; // RL2
        end
        // Flags are taken from the next sum so they line up with the result
        s_d.match = ((s_d.acc ^ pat.pattern) & ~pat.mask) == 48'h0; // RL8
        s_d.bmatch = ((s_d.acc ^ ~pat.pattern) & ~pat.mask) == 48'h0; // RL8
        s_d.wide_match = s_d.match & pat.casc_match; // RL9
        s_d.rnd = s_d.acc;
        // An exact midpoint goes to even; user mask picks the fraction bits
        if (ctl.round_conv && s_d.match)
        begin
            s_d.rnd[RND_BIT] = 1'b0; // RL8
        end
        s_d.xor_par = 8'h0;
        case (ctl.xor_w)
            dms_pkg::XW_12: s_d.xor_par = grp12; // RL7
            dms_pkg::XW_24:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    s_d.xor_par[k] = grp12[2*k] ^ grp12[2*k+1]; // RL7
                end
            end
            dms_pkg::XW_48:
            begin
                s_d.xor_par[0] = ^grp12[3:0]; // RL7
                s_d.xor_par[1] = ^grp12[7:4]; // RL7
            end
            dms_pkg::XW_96: s_d.xor_par[0] = ^grp12; // RL7
            default: s_d.xor_par = 8'h0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            s_q <= '0; // RL12
        end
        else if (ce)
        begin
            s_q <= s_d; // RL12
        end
    end

    assign result = s_q.acc;
    assign result_rnd = s_q.rnd;
    assign pat_match = s_q.match;
    assign pat_bmatch = s_q.bmatch;
    assign pat_wide = s_q.wide_match;
    assign xor_par = s_q.xor_par;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_reset_clear: assert property (disable iff (1'b0) !rst_b |=> result == 48'h0 && s_q.prod == 48'h0) // RL12
        else $error("reset did not clear accumulator");
    chk_hold_ce: assert property (!ce |=> $stable(result) && $stable(s_q.prod)) // RL12
        else $error("state moved with clock enable low");
    chk_mult_corner: assert property (mul_a == 27'h4000000 && mul_b == 18'h20000 |-> prod_w == 48'h080000000000) // RL1
        else $error("signed product corner wrong");
    chk_pre_sub: assert property (ctl.preadd_en && ctl.pre_sub && din.a == din.d |-> pre_w == 27'h0) // RL6
        else $error("pre-adder difference wrong");
    chk_acc_add: assert property (ce && ctl.acc_en && ctl.op == dms_pkg::OP_ACC && ctl.simd == dms_pkg::SIMD_ONE48 && ctl.bypass |=> result == 48'($past(result) + $past(din.x))) // RL2
        else $error("accumulate with bypass wrong");
    chk_lane_split: assert property (ce && ctl.acc_en && ctl.op == dms_pkg::OP_ADD && ctl.bypass && ctl.simd == dms_pkg::SIMD_FOUR12 |=> result[23:12] == 12'($past(din.y[23:12]) + $past(din.x[23:12]))) // RL4
        else $error("carry crossed a lane boundary");
    chk_logic_xor: assert property (ce && ctl.acc_en && ctl.op == dms_pkg::OP_LOGIC && ctl.logic_fn == dms_pkg::LF_XOR && ctl.bypass |=> result == ($past(din.x) ^ $past(din.y))) // RL5
        else $error("logic xor wrong");
    chk_count_up: assert property (ce && ctl.acc_en && ctl.op == dms_pkg::OP_COUNT && ctl.count_up ##1 ce && ctl.acc_en && ctl.op == dms_pkg::OP_COUNT && ctl.count_up |=> result == 48'($past(result, 2) + 48'h2)) // RL10
        else $error("up count wrong");
    chk_count_down: assert property (ce && ctl.acc_en && ctl.op == dms_pkg::OP_COUNT && !ctl.count_up |=> result == 48'($past(result) - 48'h1)) // RL10
        else $error("down count wrong");
    chk_xor_group: assert property (ce && ctl.xor_w == dms_pkg::XW_12 && ctl.bypass |=> xor_par[0] == ^$past(din.x[11:0])) // RL7
        else $error("12-bit parity wrong");
    chk_pat_flag: assert property (pat_match |-> ((result ^ $past(pat.pattern)) & ~$past(pat.mask)) == 48'h0 || !$past(ce)) // RL8
        else $error("match flag without match");
    chk_wide_chain: assert property ((pat_wide |-> pat_match) and ($past(ce) && pat_match |-> pat_wide == $past(pat.casc_match))) // RL9
        else $error("wide match without local match");
    chk_mreg_delay: assert property (ce && USE_MREG |=> s_q.prod == $past(prod_w)) // RL11
        else $error("multiplier stage not registered");
    chk_bypass_path: assert property (ctl.bypass |-> x_w == din.x) // RL3
        else $error("bypass did not select operand");

    cov_count: cover property (ce && ctl.op == dms_pkg::OP_COUNT ##1 ce && ctl.op == dms_pkg::OP_COUNT);
    cov_quad_acc: cover property (ce && ctl.op == dms_pkg::OP_ACC && ctl.simd == dms_pkg::SIMD_FOUR12);
    cov_wide: cover property (pat_wide);
    cov_round: cover property (ce && ctl.round_conv && s_d.match);

endmodule

// >>> verilog/dms_pkg.sv
// Shared widths, encodings and carriers of the multiply-accumulate slice
package dms_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int A_W = 27;
    localparam int B_W = 18;
    localparam int PROD_W = 45;
    localparam int P_W = 48;
    localparam int LANE_W = 12;
    localparam int N_LANE = 4;
    localparam int XOR_GRP = 8;
    localparam int XOR_OUT_W = 8;
    localparam logic [47:0] ACC_RST = 48'h0;
    localparam logic [47:0] COUNT_STEP = 48'h1;

    // ------------------------------------------------------------
    // Logic unit function codes
    // ------------------------------------------------------------
    localparam logic [3:0] LF_AND = 4'h0;
    localparam logic [3:0] LF_OR = 4'h1;
    localparam logic [3:0] LF_XOR = 4'h2;
    localparam logic [3:0] LF_XNOR = 4'h3;
    localparam logic [3:0] LF_NAND = 4'h4;
    localparam logic [3:0] LF_NOR = 4'h5;
    localparam logic [3:0] LF_ANDN = 4'h6;
    localparam logic [3:0] LF_ORN = 4'h7;
    localparam logic [3:0] LF_NOTX = 4'h8;
    localparam logic [3:0] LF_NOTY = 4'h9;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_ADD = 6'h01,
        OP_SUB = 6'h02,
        OP_ACC = 6'h04,
        OP_ACC_SUB = 6'h08,
        OP_LOGIC = 6'h10,
        OP_COUNT = 6'h20
    } dms_op_t;

    typedef enum logic [2:0] {
        SIMD_ONE48 = 3'h1,
        SIMD_TWO24 = 3'h2,
        SIMD_FOUR12 = 3'h4
    } dms_simd_t;

    typedef enum logic [3:0] {
        XW_12 = 4'h1,
        XW_24 = 4'h2,
        XW_48 = 4'h4,
        XW_96 = 4'h8
    } dms_xorw_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        dms_op_t op;
        dms_simd_t simd;
        dms_xorw_t xor_w;
        logic [3:0] logic_fn;
        logic bypass;
        logic preadd_en;
        logic pre_sub;
        logic count_up;
        logic acc_en;
        logic round_conv;
    } dms_ctl_t;

    typedef struct packed {
        logic [26:0] a;
        logic [26:0] d;
        logic [17:0] b;
        logic [47:0] x;
        logic [47:0] y;
    } dms_din_t;

    typedef struct packed {
        logic [47:0] pattern;
        logic [47:0] mask;
        logic casc_match;
    } dms_pat_t;

    typedef struct packed {
        logic [26:0] pre;
        logic [17:0] b;
        logic [47:0] prod;
        logic [47:0] acc;
        logic [47:0] rnd;
        logic match;
        logic bmatch;
        logic wide_match;
        logic [7:0] xor_par;
    } dms_state_t;

endpackage

// >>> verilog/dms_simd_add.sv
// Lane-split adder and subtractor for the slice
`timescale 1ns/1ps
module dms_simd_add #(
    parameter int LANE_W = dms_pkg::LANE_W,
    parameter int N_LANE = dms_pkg::N_LANE
) (
    input wire logic [LANE_W*N_LANE-1:0] op_a,
    input wire logic [LANE_W*N_LANE-1:0] op_b,
    input wire logic sub,
    input wire dms_pkg::dms_simd_t simd,
    output logic [LANE_W*N_LANE-1:0] sum
);

    // ------------------------------------------------------------
    // Carry chain broken at lane boundaries
    // ------------------------------------------------------------
    logic [N_LANE:0] carry;
    logic [N_LANE-1:0] split;

    // Boundary i sits below lane i; lane 0 always starts fresh
    always_comb
    begin
        split = '0;
        split[0] = 1'b1;
        if (simd == dms_pkg::SIMD_FOUR12)
        begin
            split = '1;
        end
        else if (simd == dms_pkg::SIMD_TWO24)
        begin
            split[N_LANE/2] = 1'b1;
        end
    end

    assign carry[0] = sub;

    genvar i;
    generate
        for (i = 0; i < N_LANE; i++)
        begin : g_lane
            logic cin;
            logic [LANE_W:0] lsum;
            // Subtract is a + ~b + 1, with the +1 injected at each split lane
            assign cin = split[i] ? sub : carry[i]; // RL4
            assign lsum = {1'b0, op_a[i*LANE_W +: LANE_W]}
                + {1'b0, op_b[i*LANE_W +: LANE_W] ^ {LANE_W{sub}}}
                + {{LANE_W{1'b0}}, cin}; // RL4
            assign sum[i*LANE_W +: LANE_W] = lsum[LANE_W-1:0];
            assign carry[i+1] = lsum[LANE_W];
        end
    endgenerate

endmodule

// >>> verif/dms_fabric_model.sv
// Fabric-side register that captures the slice result
`timescale 1ns/1ps
module dms_fabric_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [47:0] result,
    output logic [47:0] cap_q
);
    // ------------------------------------------------------------
    // Capture register
    // ------------------------------------------------------------
    // Shares clock and enable with the slice, so a frozen slice is never resampled
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cap_q <= 48'h0;
        end
        else if (ce)
        begin
            cap_q <= result;
        end
    end
endmodule

// >>> verif/dms_slice_tb.sv
// Self-checking testbench of the multiply-accumulate slice
`timescale 1ns/1ps
module dms_slice_tb;
    logic core_clk;
    logic rst_b;
    logic ce;
    dms_pkg::dms_ctl_t ctl;
    dms_pkg::dms_din_t din;
    dms_pkg::dms_pat_t pat;
    logic [47:0] result;
    logic [47:0] result_rnd;
    logic pat_match;
    logic pat_bmatch;
    logic pat_wide;
    logic [7:0] xor_par;
    logic [47:0] cap_q;
    int n_mismatch;
    int n_tests;

    dms_slice dms_slice_inst (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .ctl(ctl),
        .din(din), .pat(pat), .result(result), .result_rnd(result_rnd),
        .pat_match(pat_match), .pat_bmatch(pat_bmatch), .pat_wide(pat_wide),
        .xor_par(xor_par));
    dms_fabric_model dms_fabric_model_inst (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .result(result), .cap_q(cap_q));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs only change just after a falling edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic base();
        ctl = '0;
        ctl.op = dms_pkg::OP_ADD;
        ctl.simd = dms_pkg::SIMD_ONE48;
        ctl.xor_w = dms_pkg::XW_96;
        ctl.bypass = 1'b1;
        ctl.acc_en = 1'b1;
        din = '0;
        pat = '0;
        ce = 1'b1;
    endtask

    task automatic reset_for(input int n);
        rst_b = 1'b0;
        tick(n);
        rst_b = 1'b1;
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        base();
        ctl.op = dms_pkg::OP_ACC;
        din.x = 48'h7;
        tick(2);
        ce = 1'b0;
        reset_for(1);
        check("reset result", result, 48'h0);
        check("reset xor", 48'(xor_par), 48'h0);
        check("reset capture", cap_q, 48'h0);
    endtask

    task automatic test_simd();
        dms_pkg::dms_simd_t m [3] = '{dms_pkg::SIMD_ONE48, dms_pkg::SIMD_TWO24,
            dms_pkg::SIMD_FOUR12};
        logic [47:0] ea [3] = '{48'h000001000000, 48'h000000000000, 48'h000000fff000};
        logic [47:0] es [3] = '{48'hffffffffffff, 48'h000000ffffff, 48'h000000000fff};
        for (int i = 0; i < 3; i++)
        begin
            base();
            ctl.simd = m[i];
            din.x = 48'h000000ffffff;
            din.y = 48'h1;
            tick(1);
            check("lane add", result, ea[i]);
            ctl.op = dms_pkg::OP_SUB;
            din.x = 48'h1;
            din.y = 48'h0;
            tick(1);
            check("lane sub", result, es[i]);
        end
    endtask

    task automatic test_mult();
        base();
        ctl.bypass = 1'b0;
        din.a = 27'h7fffffd;
        din.b = 18'h3fff9;
        din.d = 27'h5;
        tick(3);
        check("signed product", result, 48'h15);
        ctl.preadd_en = 1'b1;
        tick(2);
        check("pipeline old", result, 48'h15);
        tick(1);
        check("preadd sum", result, 48'hfffffffffff2);
        ctl.pre_sub = 1'b1;
        tick(3);
        check("preadd diff", result, 48'hffffffffffc8);
        din.d = din.a;
        tick(3);
        check("preadd zero", result, 48'h0);
        ctl.preadd_en = 1'b0;
        din.a = 27'h4000000;
        din.b = 18'h20000;
        tick(3);
        check("product corner", result, 48'h080000000000);
    endtask

    task automatic test_acc();
        base();
        reset_for(2);
        ctl.op = dms_pkg::OP_ACC;
        din.x = 48'h5;
        tick(4);
        check("acc sum", result, 48'h14);
        ctl.acc_en = 1'b0;
        tick(2);
        check("acc hold", result, 48'h14);
        ctl.acc_en = 1'b1;
        ce = 1'b0;
        tick(2);
        check("ce freeze", result, 48'h14);
        check("capture", cap_q, 48'h14);
        ce = 1'b1;
        ctl.op = dms_pkg::OP_ACC_SUB;
        tick(1);
        check("acc sub", result, 48'hf);
    endtask

    task automatic test_count();
        base();
        reset_for(2);
        ctl.op = dms_pkg::OP_COUNT;
        ctl.count_up = 1'b1;
        tick(3);
        check("count up", result, 48'h3);
        ctl.count_up = 1'b0;
        tick(5);
        check("count down", result, 48'hfffffffffffe);
    endtask

    task automatic test_logic();
        logic [47:0] x = 48'hff00ff00ff00;
        logic [47:0] y = 48'hf0f0f0f0f0f0;
        logic [47:0] e [10] = '{x & y, x | y, x ^ y, ~(x ^ y), ~(x & y), ~(x | y),
            x & ~y, x | ~y, ~x, ~y};
        base();
        ctl.op = dms_pkg::OP_LOGIC;
        din.x = x;
        din.y = y;
        for (int i = 0; i < 10; i++)
        begin
            ctl.logic_fn = 4'(i);
            tick(1);
            check("logic fn", result, e[i]);
        end
    endtask

    task automatic test_xor();
        dms_pkg::dms_xorw_t w [4] = '{dms_pkg::XW_12, dms_pkg::XW_24, dms_pkg::XW_48,
            dms_pkg::XW_96};
        logic [7:0] e [4] = '{8'h13, 8'h04, 8'h02, 8'h01};
        base();
        din.x = 48'h000000001001;
        din.y = 48'h1;
        for (int i = 0; i < 4; i++)
        begin
            ctl.xor_w = w[i];
            tick(1);
            check("xor parity", 48'(xor_par), 48'(e[i]));
        end
    endtask

    task automatic test_pat();
        base();
        ctl.op = dms_pkg::OP_LOGIC;
        ctl.logic_fn = dms_pkg::LF_AND;
        ctl.round_conv = 1'b1;
        din.x = 48'h5;
        din.y = 48'h5;
        pat.pattern = 48'h5;
        pat.casc_match = 1'b1;
        tick(1);
        check("match", 48'(pat_match), 48'h1);
        check("wide", 48'(pat_wide), 48'h1);
        check("rounded", result_rnd, 48'h4);
        pat.pattern = 48'h4;
        pat.mask = 48'h1;
        pat.casc_match = 1'b0;
        tick(1);
        check("masked match", 48'(pat_match), 48'h1);
        check("wide off", 48'(pat_wide), 48'h0);
        pat.pattern = 48'hfffffffffffa;
        pat.mask = 48'h0;
        tick(1);
        check("inverse match", 48'(pat_bmatch), 48'h1);
        check("no match", 48'(pat_match), 48'h0);
        check("unrounded", result_rnd, 48'h5);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        base();
        rst_b = 1'b0;
        tick(16);
        rst_b = 1'b1;
        test_reset();
        test_simd();
        test_mult();
        test_acc();
        test_count();
        test_logic();
        test_xor();
        test_pat();
        summarize();
    end

    // The scenarios need about 80 cycles, so 5000 leaves a wide margin
    initial
    begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule
